// ===== verilog/pbc_control.sv
// Purpose: PHY basic control register and its mode outputs
// Assumes: MAC management accesses arrive as same-clock strobes
// Notes:   Autoneg and transmit status come from pins, synchronised
`timescale 1ns/10ps
`include "pbc_regs.svh"
module pbc_control
  import pbc_pkg::*;
#(
  parameter int RST_CYCLES  = `PBC_RST_CYCLES,
  parameter int ANEG_CYCLES = `PBC_ANEG_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        mgmt_wr_i,
  input  wire logic        mgmt_rd_i,
  input  wire logic [4:0]  mgmt_addr_i,
  input  wire logic [15:0] mgmt_wdata_i,
  output logic      [15:0] mgmt_rdata_o,
  output logic             mgmt_rvalid_o,
  input  wire logic        aneg_done_i,
  input  wire logic        aneg_duplex_i,
  input  wire logic        tx_active_i,
  input  wire logic        tx_data_i,
  input  wire logic        rx_line_i,
  output logic             rx_data_o,
  output logic             line_tx_o,
  output logic             col_o,
  output logic             rate_100_o,
  output logic             full_duplex_o,
  output logic             aneg_enable_o,
  output logic             aneg_run_o,
  output logic             low_power_o,
  output logic             isolate_o,
  output logic             soft_reset_o
);
  // ==========================================================
  // Functions
  // Value loaded by a register reset, reset bit held high while it runs
  function automatic logic [15:0] ctl_reset_load();
    ctl_reset_load = `PBC_RESET_VALUE | (16'h0001 << `PBC_BIT_RESET);
  endfunction

  // ==========================================================
  // Pin synchronisation
  logic [4:0] pins_s;
  pbc_sync #(.W(5)) u_sync (
    .clk_i   (clk_i),
    .resetn_i(resetn_i),
    .d_i     ({aneg_done_i, aneg_duplex_i, tx_active_i, tx_data_i, rx_line_i}),
    .q_o     (pins_s)
  );
  wire aneg_done_s = pins_s[4];
  wire aneg_dup_s  = pins_s[3];
  wire tx_act_s    = pins_s[2];
  wire tx_dat_s    = pins_s[1];
  wire rx_line_s   = pins_s[0];

  // ==========================================================
  // Register and sequencer
  logic [15:0] ctl_r;
  logic [15:0] ctl_nxt;
  pbc_state_t  st_r;
  pbc_state_t  st_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;

  // Isolate gates the receive and transmit data paths only, not col_o; management writes land during isolate,
  // otherwise software could never leave isolate again
  wire sel        = (mgmt_addr_i == `PBC_ADDR_CONTROL);
  wire wr_hit     = mgmt_wr_i && sel;
  wire [15:0] wval = mgmt_wdata_i & `PBC_WRITE_MASK;
  wire reset_req  = wr_hit && wval[`PBC_BIT_RESET];
  wire restart    = wr_hit && wval[`PBC_BIT_ANEG_RST] && wval[`PBC_BIT_ANEG_EN];
  wire loop_on    = ctl_r[`PBC_BIT_LOOP];
  wire iso_on     = ctl_r[`PBC_BIT_ISOLATE];
  wire pwr_on     = ctl_r[`PBC_BIT_LOWPWR];
  wire in_reset   = (st_r == PBC_RESET);
  wire in_aneg    = (st_r == PBC_ANEG);

  always_comb begin
    ctl_nxt = ctl_r;
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      PBC_IDLE: begin
        if (reset_req) begin
          ctl_nxt = ctl_reset_load();
          st_nxt  = PBC_RESET;
          cnt_nxt = 16'(RST_CYCLES);
        end else if (wr_hit) begin
          ctl_nxt = wval;
          if (restart) begin
            st_nxt  = PBC_ANEG;
            cnt_nxt = 16'(ANEG_CYCLES);
          end else begin
            ctl_nxt[`PBC_BIT_ANEG_RST] = 1'b0;
          end
        end
      end
      PBC_RESET: begin
        // Management writes are dropped until the reset bit clears
        if (cnt_r <= 16'h0001) begin
          ctl_nxt = `PBC_RESET_VALUE;
          st_nxt  = PBC_IDLE;
          cnt_nxt = 16'h0000;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      PBC_ANEG: begin
        if (reset_req) begin
          ctl_nxt = ctl_reset_load();
          st_nxt  = PBC_RESET;
          cnt_nxt = 16'(RST_CYCLES);
        end else begin
          if (wr_hit) begin
            // Restart stays pending until the sequence completes
            ctl_nxt = wval;
            ctl_nxt[`PBC_BIT_ANEG_RST] = 1'b1;
          end
          if (cnt_r != 16'h0000) begin
            cnt_nxt = cnt_r - 16'h0001;
          end else if (aneg_done_s) begin
            ctl_nxt[`PBC_BIT_DUPLEX]   = aneg_dup_s;
            ctl_nxt[`PBC_BIT_ANEG_RST] = 1'b0;
            st_nxt = PBC_IDLE;
          end
        end
      end
      default: begin
        ctl_nxt = `PBC_RESET_VALUE;
        st_nxt  = PBC_IDLE;
        cnt_nxt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_r <= `PBC_RESET_VALUE;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= PBC_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mgmt_rdata_o  <= 16'h0000;
      mgmt_rvalid_o <= 1'b0;
    end else begin
      mgmt_rvalid_o <= mgmt_rd_i;
      mgmt_rdata_o  <= (mgmt_rd_i && sel) ? (ctl_r & `PBC_WRITE_MASK) : 16'h0000;
    end
  end

  // ==========================================================
  // Data path and modes
  // Isolate and low power both silence the line; isolate wins over loopback for the receiver
  wire quiet      = iso_on || pwr_on;
  wire rx_sel     = loop_on ? tx_dat_s : rx_line_s;
  wire tx_sel     = (loop_on || quiet) ? 1'b0 : tx_dat_s;
  wire col_sel    = ctl_r[`PBC_BIT_COLTEST] && tx_act_s;

  // Data outputs: one flop after the synchronised pins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_data_o <= 1'b0;
      line_tx_o <= 1'b0;
      col_o     <= 1'b0;
    end else begin
      rx_data_o <= iso_on ? 1'b0 : rx_sel;
      line_tx_o <= tx_sel;
      col_o     <= col_sel;
    end
  end

  // ==========================================================
  // Mode outputs
  // Reset values match the register's reset value field by field
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rate_100_o    <= 1'b1;
      full_duplex_o <= 1'b1;
      aneg_enable_o <= 1'b1;
    end else begin
      rate_100_o    <= ctl_r[`PBC_BIT_RATE];
      full_duplex_o <= ctl_r[`PBC_BIT_DUPLEX];
      aneg_enable_o <= ctl_r[`PBC_BIT_ANEG_EN];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_power_o <= 1'b0;
      isolate_o   <= 1'b0;
    end else begin
      low_power_o <= pwr_on;
      isolate_o   <= iso_on;
    end
  end

  // ==========================================================
  // Sequencer status
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aneg_run_o   <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      aneg_run_o   <= in_aneg;
      soft_reset_o <= in_reset;
    end
  end
endmodule

// ===== common/pbc_regs.svh
// Purpose: Constants for the PHY basic control register block
// Assumes: 16-bit management register, 100 MHz clock
// Notes:   Field positions, reset values and timing counts
// How it works
// - Bit 15 write resets all management state
// - Reset bit self-clears when reset completes
// - Bit 14 loopback detaches receiver from medium
// - Loopback returns transmit data to receive
// - Bit 8 duplex, software or autoneg writable
// - Bit 7 enables collision test mode
// - Test collision follows transmission start/stop
// - Bits 6:0 reserved, reset zero, read zero
`ifndef PBC_REGS_SVH
`define PBC_REGS_SVH
// ==========================================================
// Register address and layout
`define PBC_ADDR_CONTROL      5'h00
`define PBC_BIT_RESET         15
`define PBC_BIT_LOOP          14
`define PBC_BIT_RATE          13
`define PBC_BIT_ANEG_EN       12
`define PBC_BIT_LOWPWR        11
`define PBC_BIT_ISOLATE       10
`define PBC_BIT_ANEG_RST      9
`define PBC_BIT_DUPLEX        8
`define PBC_BIT_COLTEST       7
`define PBC_RESET_VALUE       16'h3100
`define PBC_WRITE_MASK        16'hFF80
// ==========================================================
// Timing
`define PBC_RST_TIME_NS       100
`define PBC_CLK_NS            10
`define PBC_RST_CYCLES        ((`PBC_RST_TIME_NS + `PBC_CLK_NS - 1) / `PBC_CLK_NS)
`define PBC_ANEG_CYCLES       4
`endif

// ===== common/pbc_pkg.sv
// Purpose: Types for the PHY basic control register block
// Assumes: Included with pbc_regs.svh
// Notes:   Types only
package pbc_pkg;
  typedef enum logic [1:0] {
    PBC_IDLE  = 2'b00,
    PBC_RESET = 2'b01,
    PBC_ANEG  = 2'b10
  } pbc_state_t;
endpackage

// ===== verilog/pbc_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Single clock domain
// Notes:   First stage read only by second stage
`timescale 1ns/10ps
module pbc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// ===== dv/pbc_control_assertions.sv
// Purpose: Port checks for pbc_control
// Assumes: One clock, reset active low
// Notes:   Bound to every pbc_control
`timescale 1ns/10ps
module pbc_control_chk (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        mgmt_wr_i,
  input wire logic        mgmt_rd_i,
  input wire logic [4:0]  mgmt_addr_i,
  input wire logic [15:0] mgmt_wdata_i,
  input wire logic [15:0] mgmt_rdata_o,
  input wire logic        mgmt_rvalid_o,
  input wire logic        aneg_duplex_i,
  input wire logic        tx_active_i,
  input wire logic        line_tx_o,
  input wire logic        col_o,
  input wire logic        rate_100_o,
  input wire logic        full_duplex_o,
  input wire logic        aneg_enable_o,
  input wire logic        aneg_run_o,
  input wire logic        low_power_o,
  input wire logic        soft_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_rd_valid: assert property (mgmt_rvalid_o == $past(mgmt_rd_i))
    else $error("read valid late");
  a_rsvd_zero: assert property (mgmt_rvalid_o |-> mgmt_rdata_o[6:0] == 7'h00)
    else $error("reserved bits set");
  a_sreset_go: assert property (mgmt_wr_i && mgmt_addr_i == 5'h00 && mgmt_wdata_i[15]
    && !soft_reset_o |-> ##2 soft_reset_o)
    else $error("reset not started");
  a_sreset_end: assert property ($rose(soft_reset_o) |-> soft_reset_o[*8] ##[1:12] !soft_reset_o)
    else $error("reset length");
  a_sreset_dflt: assert property ($fell(soft_reset_o) |-> rate_100_o && aneg_enable_o
    && !low_power_o)
    else $error("defaults lost");
  a_col_idle: assert property (!tx_active_i [*4] |-> !col_o)
    else $error("collision without tx");
  a_power_line: assert property (low_power_o && $past(low_power_o) |-> !line_tx_o)
    else $error("line driven");
  a_aneg_dplx: assert property ($fell(aneg_run_o) && !soft_reset_o |-> ##2 full_duplex_o == aneg_duplex_i)
    else $error("duplex not taken");
endmodule
bind pbc_control pbc_control_chk i_chk (.*);

// ===== dv/pbc_mac_model.sv
// Purpose: Management master in place of the on-chip MAC
// Assumes: Strobes change at the falling edge
// Notes:   Also drives a busy receive line
`timescale 1ns/10ps
`include "pbc_regs.svh"
module pbc_mac_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output logic             wr_o    = 1'b0,
  output logic             rd_o    = 1'b0,
  output logic [4:0]       addr_o  = 5'h00,
  output logic [15:0]      wdata_o = 16'h0000,
  output logic             line_o  = 1'b0
);
  // Medium never idles, so a stuck receive path shows at once
  always @(negedge clk_i) line_o <= ~line_o;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d & `PBC_WRITE_MASK;
    @(negedge clk_i);
    wr_o = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(negedge clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    rd_o = 1'b0;
    ok = rvalid_i;
    d = rdata_i;
  endtask
endmodule

// ===== dv/tb.sv
// Purpose: Self-checking bench for pbc_control
// Assumes: Inputs change at the falling edge
// Notes:   Restart waits are bounded
`timescale 1ns/10ps
`include "pbc_regs.svh"
module tb;
  logic        clk_i, resetn_i, mgmt_wr_i, mgmt_rd_i, mgmt_rvalid_o, ok, aneg_done_i;
  logic        aneg_duplex_i, tx_active_i, tx_data_i, rx_line_i, rx_data_o, line_tx_o, col_o;
  logic        rate_100_o, full_duplex_o, aneg_enable_o, aneg_run_o, low_power_o;
  logic        isolate_o, soft_reset_o;
  logic [4:0]  mgmt_addr_i;
  logic [15:0] mgmt_wdata_i, mgmt_rdata_o, rd_v;
  int          n_errors = 0;
  int          checks = 0;
  pbc_control #(.RST_CYCLES(10), .ANEG_CYCLES(4)) i_dut (.*);
  pbc_mac_model i_mac (.clk_i(clk_i), .rdata_i(mgmt_rdata_o), .rvalid_i(mgmt_rvalid_o),
    .wr_o(mgmt_wr_i), .rd_o(mgmt_rd_i), .addr_o(mgmt_addr_i), .wdata_o(mgmt_wdata_i),
    .line_o(rx_line_i));
  task automatic print_verdict();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    i_mac.rd(a, rd_v, ok);
    chkb("rvalid", 1'b1, ok);
    chk("control", e, rd_v);
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 40 && (aneg_run_o !== 1'b0 || soft_reset_o !== 1'b0); i++) begin
      @(negedge clk_i);
    end
    if (aneg_run_o !== 1'b0 || soft_reset_o !== 1'b0) begin
      n_errors++;
      print_verdict();
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    resetn_i = 1'b0;
    aneg_done_i = 1'b0;
    aneg_duplex_i = 1'b0;
    tx_active_i = 1'b0;
    tx_data_i = 1'b0;
    repeat (6) @(negedge clk_i);
    resetn_i = 1'b1;
    i_mac.wr(5'h01, 16'hFF80);
    rchk(5'h00, `PBC_RESET_VALUE);
    rchk(5'h01, 16'h0000);
    i_mac.wr(5'h00, 16'h4100);
    for (int v = 1; v >= 0; v--) begin
      tx_data_i = v[0];
      repeat (5) @(negedge clk_i);
      chkb("rx_data", v[0], rx_data_o);
      chkb("line_tx", 1'b0, line_tx_o);
    end
    chkb("rate_100", 1'b0, rate_100_o);
    i_mac.wr(5'h00, 16'h0080);
    for (int v = 1; v >= 0; v--) begin
      tx_active_i = v[0];
      tx_data_i = v[0];
      repeat (5) @(negedge clk_i);
      chkb("col", v[0], col_o);
      chkb("line_tx_on", v[0], line_tx_o);
    end
    chkb("full_duplex", 1'b0, full_duplex_o);
    i_mac.wr(5'h00, 16'h0C00);
    repeat (5) @(negedge clk_i);
    chkb("low_power", 1'b1, low_power_o);
    chkb("isolate", 1'b1, isolate_o);
    chkb("rx_isolated", 1'b0, rx_data_o);
    i_mac.wr(5'h00, 16'h0200);
    rchk(5'h00, 16'h0000);
    chkb("aneg_run", 1'b0, aneg_run_o);
    i_mac.wr(5'h00, 16'h1300);
    rchk(5'h00, 16'h1300);
    chkb("aneg_run", 1'b1, aneg_run_o);
    chkb("aneg_enable", 1'b1, aneg_enable_o);
    aneg_done_i = 1'b1;
    repeat (4) @(negedge clk_i);
    wait_idle();
    rchk(5'h00, 16'h1000);
    i_mac.wr(5'h00, 16'h8000);
    i_mac.wr(5'h00, 16'h4000);
    rchk(5'h00, 16'hB100);
    chkb("soft_reset", 1'b1, soft_reset_o);
    repeat (2) @(negedge clk_i);
    wait_idle();
    rchk(5'h00, `PBC_RESET_VALUE);
    chkb("rate_100", 1'b1, rate_100_o);
    print_verdict();
  end
endmodule
